// [logic/pinmux_pkg.sv]
// Purpose: constants, register map and mode codes for the pin function select block
// Assumes: avalon-mm slave with 32-bit data, one aligned word per register
// Notes: mode pins are straps, caught once after reset release
package pinmux_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 6;
  localparam int GPIO_N = 12;
  localparam int ID_W = 16;

  localparam logic [ADDR_W-1:0] OFS_LCC = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_GPIO_OUT = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_GPIO_DIR = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_GPIO_IN = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_SUBSYS = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_EE_CTRL = 6'h20;

  localparam int LCC_PIN1_LO = 5;
  localparam int LCC_PME_EN = 7;
  localparam logic [7:0] LCC_RST = 8'h00;
  localparam logic [GPIO_N-1:0] GPIO_OUT_RST = 12'h000;
  localparam logic [GPIO_N-1:0] GPIO_DIR_RST = 12'h000;
  localparam int IRQ_PME_BIT = 12;
  localparam int IRQ_W = 13;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 13'h0000;

  localparam int EEPROM_SELECT_BIT = 0;
  localparam int EEPROM_SERIAL_CLOCK_BIT = 1;
  localparam int EEPROM_SERIAL_OUT_BIT = 2;
  localparam int EEPROM_SERIAL_IN_BIT = 3;
  localparam logic [2:0] EE_CTRL_RST = 3'h0;

  localparam int ST_FF_BIT = 3;
  localparam int ST_F1_LB = 4;
  localparam int ST_F1_PP = 5;
  localparam int ST_UNIQUE = 6;
  localparam int ST_STANDALONE = 7;
  localparam int ST_STRAP_DONE = 8;

  localparam logic [1:0] SETTLE_CYCLES = 2'h2;

  typedef enum logic [2:0] {
    MODE_QUAD_LB = 3'h0,
    MODE_QUAD_PP = 3'h1,
    MODE_QUAD_SUBID = 3'h2,
    MODE_UNIQUE_LB = 3'h3,
    MODE_ENH_LB = 3'h4,
    MODE_ENH_PP = 3'h5,
    MODE_RESERVED = 3'h6,
    MODE_STANDALONE = 3'h7
  } mode_t;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_LATCH = 2'b01,
    ST_RUN = 2'b11
  } strap_state_t;
endpackage

// [logic/sync_two_stage.sv]
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs are levels, not pulses
// Notes: the first stage feeds only the second
`timescale 1ns/1ps
module sync_two_stage #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout <= '0;
    end else if (ce) begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// [logic/mode_pin_function_select.sv]
// Purpose: strap-driven pin function select for the gpio, pme and eeprom pins
// Assumes: straps and pins are asynchronous and pass a two-stage synchroniser
// Notes: strap levels are caught once, after the synchronisers settle
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module mode_pin_function_select (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [pinmux_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pinmux_pkg::DATA_W-1:0] avs_writedata,
  output logic [pinmux_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic [2:0] mode_strap,
  input wire logic [pinmux_pkg::GPIO_N-1:0] gpio_pins_in,
  output logic [pinmux_pkg::GPIO_N-1:0] gpio_pins_out,
  output logic [pinmux_pkg::GPIO_N-1:0] gpio_pins_oe,
  output logic pme_function1,
  input wire logic [pinmux_pkg::ID_W-1:0] sub_id_pins,
  input wire logic [pinmux_pkg::ID_W-1:0] sub_vendor_pins,
  output logic eeprom_select,
  output logic eeprom_serial_clock,
  output logic eeprom_serial_out,
  input wire logic eeprom_serial_in,
  output logic eeprom_in_pullup,
  output logic form_factor_select,
  output logic func1_local_bus,
  output logic func1_parallel,
  output logic uart_unique_bars,
  output logic standalone
);
  import pinmux_pkg::*;

  localparam int SYNC_W = 3 + GPIO_N + 1 + 2 * ID_W;

  function automatic logic full_gpio_mode(input mode_t m);
    full_gpio_mode = (m == MODE_QUAD_LB) || (m == MODE_UNIQUE_LB) || (m == MODE_ENH_LB);
  endfunction

  function automatic logic strap_ff_mode(input mode_t m);
    strap_ff_mode = (m == MODE_UNIQUE_LB) || (m == MODE_ENH_LB) || (m == MODE_ENH_PP);
  endfunction

  function automatic logic legacy_mode(input mode_t m);
    legacy_mode = (m == MODE_QUAD_LB) || (m == MODE_QUAD_PP) || (m == MODE_QUAD_SUBID);
  endfunction

  // synchronised pin levels
  logic [SYNC_W-1:0] sync_out;
  logic [2:0] mode_s;
  logic [GPIO_N-1:0] gpio_s;
  logic ee_in_s;
  logic [ID_W-1:0] sub_id_s;
  logic [ID_W-1:0] sub_vendor_s;

  sync_two_stage #(.WIDTH(SYNC_W)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .din({mode_strap, gpio_pins_in, eeprom_serial_in, sub_id_pins, sub_vendor_pins}),
    .dout(sync_out)
  );

  assign {mode_s, gpio_s, ee_in_s, sub_id_s, sub_vendor_s} = sync_out;

  // strap capture
  strap_state_t strap_q, strap_d;
  logic [1:0] settle_q;
  mode_t mode_q;
  logic ff_q;
  logic [ID_W-1:0] sub_id_q;
  logic [ID_W-1:0] sub_vendor_q;
  wire strap_run = (strap_q == ST_RUN);
  wire latch_now = (strap_q == ST_LATCH);

  always_comb begin
    strap_d = strap_q;
    case (strap_q)
      ST_SETTLE: begin
        if (settle_q == SETTLE_CYCLES) begin
          strap_d = ST_LATCH;
        end
      end
      ST_LATCH: strap_d = ST_RUN;
      default: strap_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_q <= ST_SETTLE;
      settle_q <= 2'h0;
    end else if (ce) begin
      strap_q <= strap_d;
      if (strap_q == ST_SETTLE) begin
        settle_q <= settle_q + 2'h1;
      end
    end
  end

  // the mode and form factor are straps, so later pin wiggles must not move them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_QUAD_LB;
      ff_q <= 1'b0;
      sub_id_q <= '0;
      sub_vendor_q <= '0;
    end else if (ce && latch_now) begin
      mode_q <= mode_t'(mode_s);
      ff_q <= strap_ff_mode(mode_t'(mode_s)) & gpio_s[11];
      if (mode_t'(mode_s) == MODE_QUAD_SUBID) begin
        sub_id_q <= sub_id_s;
        sub_vendor_q <= sub_vendor_s;
      end
    end
  end

  // function enables follow the caught mode; reserved codes enable nothing
  wire f1_lb_d = (mode_q == MODE_QUAD_LB) || (mode_q == MODE_UNIQUE_LB)
      || (mode_q == MODE_ENH_LB);
  wire f1_pp_d = (mode_q == MODE_QUAD_PP) || (mode_q == MODE_ENH_PP);
  wire unique_d = (mode_q == MODE_UNIQUE_LB);
  wire standalone_d = (mode_q == MODE_STANDALONE);

  // software registers
  logic [7:0] lcc_q;
  logic [GPIO_N-1:0] gpio_val_q;
  logic [GPIO_N-1:0] gpio_dir_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [2:0] ee_ctrl_q;
  logic ack_q;

  wire req = avs_read | avs_write;
  wire wr_take = ce & ack_q & avs_write;
  wire hit_lcc = (avs_address == OFS_LCC);
  wire hit_val = (avs_address == OFS_GPIO_OUT);
  wire hit_dir = (avs_address == OFS_GPIO_DIR);
  wire hit_stat = (avs_address == OFS_IRQ_STAT);
  wire hit_mask = (avs_address == OFS_IRQ_MASK);
  wire hit_ee = (avs_address == OFS_EE_CTRL);
  wire pin1_gpio = (lcc_q[LCC_PIN1_LO+1:LCC_PIN1_LO] == 2'b00);
  wire pme_en = lcc_q[LCC_PME_EN];

  // one wait cycle per access: the answer is registered and stands at the release edge
  assign avs_waitrequest = req & ~ack_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lcc_q <= LCC_RST;
      gpio_val_q <= GPIO_OUT_RST;
      gpio_dir_q <= GPIO_DIR_RST;
      irq_mask_q <= IRQ_MASK_RST;
      ee_ctrl_q <= EE_CTRL_RST;
    end else if (wr_take) begin
      if (hit_lcc) begin
        lcc_q <= avs_writedata[7:0];
      end else if (hit_val) begin
        gpio_val_q <= avs_writedata[GPIO_N-1:0];
      end else if (hit_dir) begin
        gpio_dir_q <= avs_writedata[GPIO_N-1:0];
      end else if (hit_mask) begin
        irq_mask_q <= avs_writedata[IRQ_W-1:0];
      end else if (hit_ee) begin
        ee_ctrl_q <= avs_writedata[2:0];
      end
    end
  end

  // pin function mux
  logic [GPIO_N-1:0] pin_out_d;
  logic [GPIO_N-1:0] pin_oe_d;
  wire gpio_mode = full_gpio_mode(mode_q);

  always_comb begin
    pin_out_d = gpio_val_q;
    pin_oe_d = gpio_dir_q;
    // hold pins quiet until the straps are known
    if (!strap_run) begin
      pin_out_d = '0;
      pin_oe_d = '0;
    end else begin
      if (!gpio_mode) begin
        pin_out_d[0] = 1'b0;
        pin_oe_d[0] = 1'b1;
        pin_out_d[10:3] = '0;
        pin_oe_d[10:3] = '0;
      end
      if (!pin1_gpio) begin
        pin_out_d[1] = 1'b0;
        pin_oe_d[1] = 1'b1;
      end
      if (pme_en) begin
        pin_out_d[2] = 1'b0;
        pin_oe_d[2] = 1'b0;
      end
      if (!legacy_mode(mode_q)) begin
        // strap input in enhanced modes; standalone relies on the board tie-low
        pin_out_d[11] = 1'b0;
        pin_oe_d[11] = 1'b0;
      end
    end
  end

  // irq events: rising edges on gpio inputs not being driven, and the pme input
  logic [GPIO_N-1:0] gpio_prev_q;
  logic [GPIO_N-1:0] gpio_in_fn;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  always_comb begin
    gpio_in_fn = ~pin_oe_d;
    gpio_in_fn[2] = ~pin_oe_d[2] & ~pme_en;
    if (!legacy_mode(mode_q)) begin
      gpio_in_fn[11] = 1'b0;
    end
    if (!gpio_mode) begin
      gpio_in_fn[10:3] = '0;
    end
  end

  assign irq_set = {pme_en & gpio_s[2] & ~gpio_prev_q[2],
      gpio_in_fn & gpio_s & ~gpio_prev_q & {GPIO_N{strap_run}}};
  assign irq_clr = (wr_take && hit_stat) ? avs_writedata[IRQ_W-1:0] : '0;

  // a set in the same cycle as its clear wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
      gpio_prev_q <= '0;
    end else if (ce) begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      gpio_prev_q <= gpio_s;
    end
  end

  // outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_pins_out <= '0;
      gpio_pins_oe <= '0;
      pme_function1 <= 1'b0;
      irq <= 1'b0;
      eeprom_select <= 1'b0;
      eeprom_serial_clock <= 1'b0;
      eeprom_serial_out <= 1'b0;
      form_factor_select <= 1'b0;
      func1_local_bus <= 1'b0;
      func1_parallel <= 1'b0;
      uart_unique_bars <= 1'b0;
      standalone <= 1'b0;
    end else if (ce) begin
      gpio_pins_out <= pin_out_d;
      gpio_pins_oe <= pin_oe_d;
      pme_function1 <= pme_en & gpio_s[2];
      irq <= |(irq_stat_q & irq_mask_q);
      eeprom_select <= ee_ctrl_q[EEPROM_SELECT_BIT];
      eeprom_serial_clock <= ee_ctrl_q[EEPROM_SERIAL_CLOCK_BIT];
      eeprom_serial_out <= ee_ctrl_q[EEPROM_SERIAL_OUT_BIT];
      form_factor_select <= ff_q;
      func1_local_bus <= strap_run & f1_lb_d;
      func1_parallel <= strap_run & f1_pp_d;
      uart_unique_bars <= strap_run & unique_d;
      standalone <= strap_run & standalone_d;
    end
  end

  // pad pull-up on the eeprom data input keeps an absent part reading high
  assign eeprom_in_pullup = 1'b1;

  // read data
  logic [DATA_W-1:0] rd_d;
  wire [DATA_W-1:0] status_word = {23'h0, strap_run, standalone_d, unique_d, f1_pp_d, f1_lb_d,
      ff_q, mode_q};
  wire [DATA_W-1:0] ee_word = {28'h0, ee_in_s, ee_ctrl_q};

  always_comb begin
    if (hit_lcc) begin
      rd_d = {24'h0, lcc_q};
    end else if (hit_val) begin
      rd_d = {20'h0, gpio_val_q};
    end else if (hit_dir) begin
      rd_d = {20'h0, gpio_dir_q};
    end else if (avs_address == OFS_GPIO_IN) begin
      rd_d = {20'h0, gpio_s};
    end else if (avs_address == OFS_STATUS) begin
      rd_d = status_word;
    end else if (avs_address == OFS_SUBSYS) begin
      rd_d = {sub_vendor_q, sub_id_q};
    end else if (hit_stat) begin
      rd_d = {19'h0, irq_stat_q};
    end else if (hit_mask) begin
      rd_d = {19'h0, irq_mask_q};
    end else if (hit_ee) begin
      rd_d = ee_word;
    end else begin
      rd_d = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= '0;
    end else if (ce && avs_read && !ack_q) begin
      avs_readdata <= rd_d;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_ee_write;
    wr_take && hit_ee;
  endsequence

  sequence s_subid_latch;
    ce && latch_now && (mode_t'(mode_s) == MODE_QUAD_SUBID);
  endsequence

  a_pin_zero_low: assert property (ce && strap_run && !gpio_mode
      |=> gpio_pins_oe[0] && !gpio_pins_out[0]) else $error("pin zero not driven low");
  a_pin_one_low: assert property (ce && strap_run && !pin1_gpio
      |=> gpio_pins_oe[1] && !gpio_pins_out[1]) else $error("pin one not driven low");
  a_pin_two_gpio: assert property (ce && strap_run && !pme_en
      |=> gpio_pins_oe[2] == $past(gpio_dir_q[2])) else $error("pin two not a gpio");
  a_pin_two_pme: assert property (ce && pme_en && gpio_s[2]
      |=> pme_function1 && !gpio_pins_oe[2]) else $error("pme not raised from pin two");
  a_upper_gpio: assert property (ce && strap_run && gpio_mode
      |=> gpio_pins_oe[10:3] == $past(gpio_dir_q[10:3])) else $error("upper pins wrong");
  a_form_strap: assert property (ce && strap_run && strap_ff_mode(mode_q)
      |=> !gpio_pins_oe[11] && form_factor_select == $past(ff_q))
      else $error("form factor pin driven");
  a_eeprom_drive: assert property (s_ee_write ##1 ce
      |=> eeprom_select == $past(avs_writedata[EEPROM_SELECT_BIT], 2)) else $error("eeprom select lag");
  a_pullup_on: assert property (eeprom_in_pullup) else $error("eeprom pull-up off");
  a_subid_hold: assert property (s_subid_latch
      |=> sub_id_q == $past(sub_id_s) && sub_vendor_q == $past(sub_vendor_s))
      else $error("subsystem id not caught");
  a_func_split: assert property (ce && strap_run
      |=> !(func1_local_bus && func1_parallel)) else $error("both function 1 kinds on");
  a_standalone_on: assert property (ce && strap_run && mode_q == MODE_STANDALONE
      |=> standalone && !func1_local_bus) else $error("standalone not selected");
  a_bus_answer: assert property (req && !ack_q && ce |=> !avs_waitrequest || !req)
      else $error("bus answer late");
endmodule

// [tb/board_model.sv]
// Purpose: board straps, gpio wiring and serial eeprom beside the pin select block
// Assumes: a fitted eeprom answers with the inverse of the last bit clocked in
// Notes: a deselected eeprom releases its data line to the pull-up
`timescale 1ns/1ps
module board_model (
  input wire logic [2:0] mode_sel,
  input wire logic fitted,
  input wire logic standalone_board,
  input wire logic [11:0] ext,
  input wire logic [11:0] gpio_pins_out,
  input wire logic [11:0] gpio_pins_oe,
  input wire logic eeprom_select,
  input wire logic eeprom_serial_clock,
  input wire logic eeprom_serial_out,
  input wire logic eeprom_in_pullup,
  output logic [2:0] mode_strap,
  output logic [11:0] gpio_pins_in,
  output logic eeprom_serial_in
);
  logic last_bit = 1'b0;
  // only assigned codes are ever strapped
  assign mode_strap = mode_sel;
  // a standalone board holds every undriven pin low
  assign gpio_pins_in = (gpio_pins_oe & gpio_pins_out) |
    (~gpio_pins_oe & (standalone_board ? 12'h000 : ext));
  always @(posedge eeprom_serial_clock) if (eeprom_select) last_bit <= eeprom_serial_out;
  assign eeprom_serial_in = (fitted && eeprom_select) ? ~last_bit :
    (eeprom_in_pullup ? 1'b1 : ~last_bit);
endmodule

// [tb/mode_pin_function_select_test.sv]
// Purpose: self-checking bench for the strap-driven pin function select
// Assumes: one request at a time on the register bus, answer after any number of stall cycles
// Notes: expected values go into a queue, a watcher compares them in order
`timescale 1ns/1ps
module mode_pin_function_select_test;
  import pinmux_pkg::*;
  typedef struct {int kind; logic [31:0] exp; logic [31:0] mask;} note_t;
  logic clk = 0, rst_n = 0, ce = 1, avs_read = 0, avs_write = 0;
  logic [ADDR_W-1:0] avs_address = 6'h00;
  logic [DATA_W-1:0] avs_writedata = 32'h0, avs_readdata, got;
  logic avs_waitrequest, irq, pme_function1, eeprom_select, eeprom_serial_clock;
  logic eeprom_serial_out, eeprom_serial_in, eeprom_in_pullup, form_factor_select;
  logic func1_local_bus, func1_parallel, uart_unique_bars, standalone;
  logic [2:0] mode_strap, mode_sel = 3'h0, m;
  logic [11:0] gpio_pins_in, gpio_pins_out, gpio_pins_oe, ext = 12'h000;
  logic [11:0] val, eoe, gm, msk;
  logic [15:0] sub_id_pins = 16'h0000, sub_vendor_pins = 16'h0000, rnd = 16'h0008, sid;
  logic [7:0] local_config_control;
  logic fitted = 0, sa_board = 0, g0, enh, ff;
  int n_errors = 0, cmp_count = 0;
  note_t q[$], nt;
  event look;
  string kname[4] = '{"readdata", "gpio_pins_out", "gpio_pins_oe", "status_pins"};
  wire [31:0] misc = {21'h0, eeprom_in_pullup, eeprom_serial_out, eeprom_serial_clock,
    eeprom_select, pme_function1, irq, form_factor_select, func1_local_bus,
    func1_parallel, uart_unique_bars, standalone};

  mode_pin_function_select u_mode_pin_function_select (.clk(clk), .rst_n(rst_n), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .mode_strap(mode_strap),
    .gpio_pins_in(gpio_pins_in), .gpio_pins_out(gpio_pins_out), .gpio_pins_oe(gpio_pins_oe),
    .pme_function1(pme_function1), .sub_id_pins(sub_id_pins),
    .sub_vendor_pins(sub_vendor_pins), .eeprom_select(eeprom_select),
    .eeprom_serial_clock(eeprom_serial_clock), .eeprom_serial_out(eeprom_serial_out),
    .eeprom_serial_in(eeprom_serial_in), .eeprom_in_pullup(eeprom_in_pullup),
    .form_factor_select(form_factor_select), .func1_local_bus(func1_local_bus),
    .func1_parallel(func1_parallel), .uart_unique_bars(uart_unique_bars),
    .standalone(standalone));

  board_model u_board_model (.mode_sel(mode_sel), .fitted(fitted),
    .standalone_board(sa_board), .ext(ext), .gpio_pins_out(gpio_pins_out),
    .gpio_pins_oe(gpio_pins_oe), .eeprom_select(eeprom_select),
    .eeprom_serial_clock(eeprom_serial_clock), .eeprom_serial_out(eeprom_serial_out),
    .eeprom_in_pullup(eeprom_in_pullup), .mode_strap(mode_strap),
    .gpio_pins_in(gpio_pins_in), .eeprom_serial_in(eeprom_serial_in));

  initial begin
    forever #5 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic note(input int k, input logic [31:0] e, input logic [31:0] mk);
    q.push_back('{k, e, mk});
    -> look;
  endtask

  // results are taken between edges, where nothing is switching
  task automatic peek(input int k, input logic [31:0] e, input logic [31:0] mk);
    @(negedge clk);
    note(k, e, mk);
  endtask

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
    input logic [31:0] e);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // no stall length is assumed: a hung slave is ended by the watchdog alone
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    // read data is taken at the very edge that sees waitrequest low
    if (!wr) note(0, e, 32'hffffffff);
    avs_read <= 0;
    avs_write <= 0;
  endtask

  // straps and id pins are only caught after a reset, so each mode needs one
  task automatic boot(input logic [2:0] md);
    @(posedge clk);
    rst_n <= 0;
    mode_sel <= md;
    sa_board <= (md == 3'h7);
    rnd = lfsr(rnd);
    sid = rnd;
    ff = rnd[0];
    ext <= {rnd[0] && md >= 3'h3, 11'h000};
    sub_id_pins <= rnd;
    sub_vendor_pins <= ~rnd;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (10) @(posedge clk);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(look) begin
    nt = q.pop_front();
    got = nt.kind == 0 ? avs_readdata : nt.kind == 1 ? {20'h0, gpio_pins_out} :
      nt.kind == 2 ? {20'h0, gpio_pins_oe} : misc;
    cmp_count++;
    if ((got & nt.mask) !== (nt.exp & nt.mask)) begin
      $display("mismatch %s expected %h seen %h", kname[nt.kind], nt.exp & nt.mask,
        got & nt.mask);
      n_errors++;
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 8; i++) begin
      if (i == 6) continue;
      m = i[2:0];
      boot(m);
      rnd = lfsr(rnd);
      val = rnd[11:0];
      local_config_control = {m[2], m[1:0], 5'h00};
      g0 = (m == 3'h0 || m == 3'h3 || m == 3'h4);
      enh = (m >= 3'h3 && m <= 3'h5);
      bus(0, OFS_STATUS, 0, {23'h0, 1'b1, m == 3'h7, m == 3'h3, m == 3'h1 || m == 3'h5,
        g0, enh & ff, m});
      peek(3, {27'h0, enh & ff, g0, m == 3'h1 || m == 3'h5, m == 3'h3, m == 3'h7},
        32'h1f);
      bus(1, OFS_LCC, {24'h0, local_config_control}, 0);
      bus(1, OFS_GPIO_DIR, 32'hfff, 0);
      bus(1, OFS_GPIO_OUT, {20'h0, val}, 0);
      gm = (g0 ? 12'h7f9 : 12'h000) | (local_config_control[6:5] == 2'b00 ? 12'h002 : 12'h000) |
        (local_config_control[7] ? 12'h000 : 12'h004) | (m <= 3'h2 ? 12'h800 : 12'h000);
      eoe = 12'h003 | (local_config_control[7] ? 12'h000 : 12'h004) | (g0 ? 12'h7f8 : 12'h000) |
        (m <= 3'h2 ? 12'h800 : 12'h000);
      // pin two is left unchecked in the id and standalone modes
      msk = (m == 3'h2 || m == 3'h7) ? 12'hffb : 12'hfff;
      peek(2, {20'h0, eoe}, {20'h0, msk});
      peek(1, {20'h0, val & gm}, {20'h0, msk & eoe});
      if (m == 3'h2) begin
        bus(0, OFS_SUBSYS, 0, {~sid, sid});
        sub_id_pins <= ~sid;
        bus(0, OFS_SUBSYS, 0, {~sid, sid});
      end
      $display("test mode %0d done", m);
    end
    boot(3'h0);
    bus(1, OFS_IRQ_MASK, 32'h1000, 0);
    bus(1, OFS_LCC, 32'h80, 0);
    ext <= 12'h004;
    repeat (6) @(posedge clk);
    peek(3, 32'h60, 32'h60);
    bus(0, OFS_IRQ_STAT, 0, 32'h1000);
    bus(1, OFS_IRQ_STAT, 32'h1000, 0);
    repeat (2) @(posedge clk);
    peek(3, 0, 32'h20);
    @(posedge clk);
    ext <= 12'h024;
    repeat (6) @(posedge clk);
    bus(0, OFS_IRQ_STAT, 0, 32'h20);
    peek(3, 0, 32'h20);
    bus(1, OFS_IRQ_MASK, 32'h20, 0);
    repeat (2) @(posedge clk);
    peek(3, 32'h20, 32'h20);
    bus(1, OFS_LCC, 0, 0);
    repeat (2) @(posedge clk);
    peek(3, 0, 32'h40);
    bus(0, OFS_GPIO_IN, 0, 32'h24);
    $display("test interrupts done");
    bus(0, OFS_EE_CTRL, 0, 32'h8);
    fitted <= 1;
    bus(1, OFS_EE_CTRL, 32'h5, 0);
    bus(1, OFS_EE_CTRL, 32'h7, 0);
    repeat (4) @(posedge clk);
    peek(3, 32'h780, 32'h780);
    bus(0, OFS_EE_CTRL, 0, 32'h7);
    bus(1, OFS_EE_CTRL, 0, 0);
    repeat (4) @(posedge clk);
    bus(0, OFS_EE_CTRL, 0, 32'h8);
    bus(1, 6'h3c, 32'hffffffff, 0);
    bus(0, 6'h3c, 0, 0);
    bus(0, 6'h24, 0, 0);
    $display("test eeprom and unmapped done");
    conclude();
  end
endmodule
